// ---- rtl/adc_spi_pkg.sv ----
package adc_spi_pkg;
	localparam int          NCH          = 3;
	localparam int          DW           = 24;
	localparam int          RAW_W        = 26;
	localparam int          REG_N        = 8;
	// register indices, reachable by both the host port and the serial link
	localparam logic [5:0]  REG_ID       = 6'h00;
	localparam logic [5:0]  REG_STATUS   = 6'h01;
	localparam logic [5:0]  REG_MODE     = 6'h02;
	// identity value is arbitrary
	localparam logic [15:0] ID_VALUE     = 16'h5a00;
	// mode register fields and reset value
	localparam int          MODE_SEL_LSB = 0;
	localparam int          MODE_FMT_BIT = 2;
	localparam int          MODE_TO_BIT  = 4;
	localparam int          MODE_GC_BIT  = 5;
	localparam int          MODE_WL_LSB  = 8;
	localparam logic [15:0] MODE_RST     = 16'h0110;
	// word length encodings
	localparam logic [1:0]  WL_16        = 2'h0;
	localparam logic [1:0]  WL_24        = 2'h1;
	localparam logic [1:0]  WL_32Z       = 2'h2;
	localparam logic [1:0]  WL_32S       = 2'h3;
	// command words and fixed responses
	localparam logic [15:0] CMD_NULL     = 16'h0000;
	localparam logic [15:0] CMD_RESET    = 16'h0011;
	localparam logic [15:0] CMD_STANDBY  = 16'h0022;
	localparam logic [15:0] CMD_WAKEUP   = 16'h0033;
	localparam logic [15:0] CMD_LOCK     = 16'h0555;
	localparam logic [15:0] CMD_UNLOCK   = 16'h0655;
	localparam logic [15:0] RESP_RESET   = 16'hff23;
	localparam logic [2:0]  OP_REGISTER_READ_CMD      = 3'h5;
	localparam logic [2:0]  OP_REGISTER_WRITE_CMD      = 3'h3;
	localparam logic [2:0]  OP_WACK      = 3'h2;
	localparam logic [15:0] REGISTER_READ_CMD_ACK     = 16'h4000;
	localparam logic [7:0]  STD_WORDS    = 8'h05;
	// output crc
	localparam logic [15:0] CRC_INIT     = 16'hffff;
	localparam logic [15:0] CRC_POLY     = 16'h1021;
	// pin vector positions and idle levels
	localparam int          PIN_CS       = 0;
	localparam int          PIN_SCLK     = 1;
	localparam int          PIN_DIN      = 2;
	localparam int          PIN_SYNC     = 3;
	localparam logic [3:0]  PIN_IDLE     = 4'h9;
	// timing
	localparam int          CLK_NS       = 10;
	localparam int          RDY_PULSE_NS = 40;
	localparam logic [3:0]  RDY_PULSE_CYC =
		4'((RDY_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam int unsigned TIMEOUT_CYC  = 32768;
	typedef enum logic [1:0] {
		LS_IDLE = 2'b01,
		LS_ACT  = 2'b10
	} link_state_t;
endpackage : adc_spi_pkg

// ---- rtl/adc_spi_frame_out.sv ----
module adc_spi_frame_out #(
	parameter int unsigned FRAME_TIMEOUT_CYC = adc_spi_pkg::TIMEOUT_CYC
) (
	input  wire logic                             mclk,
	input  wire logic                             sys_rst,
	input  wire logic                             cs_n_pin,
	input  wire logic                             sclk_pin,
	input  wire logic                             din_pin,
	input  wire logic                             sync_reset_n_pin,
	output logic                                  dout,
	output logic                                  dout_oe,
	output logic                                  sample_ready_n,
	input  wire logic [adc_spi_pkg::NCH-1:0]      ch_done,
	input  wire logic [adc_spi_pkg::RAW_W-1:0]    ch0_raw,
	input  wire logic [adc_spi_pkg::RAW_W-1:0]    ch1_raw,
	input  wire logic [adc_spi_pkg::RAW_W-1:0]    ch2_raw,
	input  wire logic [3:0]                       reg_addr,
	input  wire logic [15:0]                      reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic [15:0]                           reg_rdata
);
	import adc_spi_pkg::*;

	function automatic logic [5:0] word_bits(input logic [1:0] wl);
		word_bits = (wl == WL_16) ? 6'd16 : (wl == WL_24) ? 6'd24 : 6'd32;
	endfunction : word_bits

	function automatic logic [DW-1:0] sat24(input logic [RAW_W-1:0] raw);
		if ($signed(raw) > $signed(26'h07fffff))
			sat24 = 24'h7fffff;
		else if ($signed(raw) < $signed(26'h3800000))
			sat24 = 24'h800000;
		else
			sat24 = raw[DW-1:0];
	endfunction : sat24

	logic [15:0]       regs_r [REG_N];
	logic [15:0]       status_w;

	function automatic logic [15:0] reg_val(input logic [5:0] a);
		if (a == REG_ID)
			reg_val = ID_VALUE;
		else if (a == REG_STATUS)
			reg_val = status_w;
		else if (a < 6'(REG_N))
			reg_val = regs_r[a[2:0]];
		else
			reg_val = 16'h0000;
	endfunction : reg_val

	// pin synchronisers: a change counts once stages two and three agree
	logic [3:0]        pin_s0_r, pin_s1_r, pin_s2_r, pin_lvl_r;
	wire  [3:0]        pins_in   = {sync_reset_n_pin, din_pin, sclk_pin,
		cs_n_pin};
	wire  [3:0]        pin_agree = ~(pin_s1_r ^ pin_s2_r);
	wire  [3:0]        pin_nxt   = (pin_agree & pin_s2_r) |
		(~pin_agree & pin_lvl_r);
	wire  [3:0]        pin_rise  = pin_nxt & ~pin_lvl_r;
	wire  [3:0]        pin_fall  = ~pin_nxt & pin_lvl_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pin_s0_r  <= PIN_IDLE;
			pin_s1_r  <= PIN_IDLE;
			pin_s2_r  <= PIN_IDLE;
			pin_lvl_r <= PIN_IDLE;
		end else begin
			pin_s0_r  <= pins_in;
			pin_s1_r  <= pin_s0_r;
			pin_s2_r  <= pin_s1_r;
			pin_lvl_r <= pin_nxt;
		end
	end

	wire  [1:0]        wl_sel    = regs_r[REG_MODE[2:0]][MODE_WL_LSB+:2];
	wire  [1:0]        rdy_src   = regs_r[REG_MODE[2:0]][MODE_SEL_LSB+:2];
	wire               rdy_fmt   = regs_r[REG_MODE[2:0]][MODE_FMT_BIT];
	wire               to_en     = regs_r[REG_MODE[2:0]][MODE_TO_BIT];
	wire               gchop     = regs_r[REG_MODE[2:0]][MODE_GC_BIT];
	wire  [5:0]        wbits     = word_bits(wl_sel);
	wire               selected  = ~pin_lvl_r[PIN_CS];
	wire               cs_rise   = pin_rise[PIN_CS];
	wire               sync_ev   = pin_fall[PIN_SYNC];
	wire               rise_ev   = selected & pin_rise[PIN_SCLK];
	wire               fall_ev   = selected & pin_fall[PIN_SCLK];

	link_state_t       state_r;
	logic [16:0]       to_cnt_r;
	logic [5:0]        bit_cnt_r, tx_cnt_r;
	logic [7:0]        word_r, frame_len_r, out_len_r;
	logic [31:0]       rx_sh_r, tx_sh_r;
	logic [15:0]       cmd_r, resp_r, crc_r;
	logic              cmd_seen_r, rmulti_r, lock_r, tx_crc_r, dout_r;
	logic [5:0]        rm_addr_r, wr_addr_r;
	logic [6:0]        rm_n_r, wr_cnt_r;

	wire  [31:0]       rx_nxt    = {rx_sh_r[30:0], pin_lvl_r[PIN_DIN]};
	wire  [15:0]       rx_word   = (wl_sel == WL_16) ? rx_nxt[15:0] :
		(wl_sel == WL_24) ? rx_nxt[23:8] : rx_nxt[31:16];
	wire               word_done = fall_ev & (bit_cnt_r == wbits - 6'd1);
	wire               frame_full = word_done &
		(word_r + 8'd1 == frame_len_r);
	wire               timeout_hit = to_en & (state_r == LS_ACT) &
		(to_cnt_r == 17'(FRAME_TIMEOUT_CYC));
	wire               latch     = cmd_seen_r & (cs_rise | frame_full);
	wire               frame_rst = cs_rise | frame_full | timeout_hit |
		~selected;
	wire               first_w   = word_done & (word_r == 8'd0);

	// command classification of the frame's own command word
	wire               is_register_read_cmd   = cmd_r[15:13] == OP_REGISTER_READ_CMD;
	wire               is_register_write_cmd   = cmd_r[15:13] == OP_REGISTER_WRITE_CMD;
	wire               is_fixed  = cmd_r == CMD_RESET ||
		cmd_r == CMD_STANDBY || cmd_r == CMD_WAKEUP ||
		cmd_r == CMD_LOCK || cmd_r == CMD_UNLOCK;
	wire               allowed   = ~lock_r | is_register_read_cmd | cmd_r == CMD_UNLOCK;
	wire               accept    = allowed & (is_register_read_cmd | is_register_write_cmd | is_fixed);
	wire  [15:0]       resp_nxt  =
		~accept ? status_w :
		(cmd_r == CMD_RESET) ? RESP_RESET :
		is_fixed ? cmd_r :
		(is_register_read_cmd & cmd_r[6:0] == 7'h00) ? reg_val(cmd_r[12:7]) :
		is_register_read_cmd ? (cmd_r | REGISTER_READ_CMD_ACK) :
		{OP_WACK, cmd_r[12:7], wr_cnt_r - 7'd1};
	wire               wr_slot   = word_done & cmd_seen_r & is_register_write_cmd &
		~lock_r & (word_r >= 8'd1) &
		(word_r <= 8'(cmd_r[6:0]) + 8'd1);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r  <= LS_IDLE;
			to_cnt_r <= 17'h00000;
		end else if (frame_rst) begin
			state_r  <= LS_IDLE;
			to_cnt_r <= 17'h00000;
		end else if (state_r == LS_ACT) begin
			to_cnt_r <= to_cnt_r + 17'h00001;
		end else if (rise_ev | fall_ev) begin
			state_r  <= LS_ACT;
		end
	end

	// input side: bits taken on sclk falling edges
	always_ff @(posedge mclk) begin
		if (sys_rst || frame_rst) begin
			bit_cnt_r   <= 6'h00;
			word_r      <= 8'h00;
			rx_sh_r     <= 32'h00000000;
			cmd_seen_r  <= 1'b0;
			if (sys_rst || timeout_hit)
				frame_len_r <= STD_WORDS;
			else if (latch)
				frame_len_r <= (is_register_read_cmd && accept &&
					cmd_r[6:0] != 7'h00) ? 8'(cmd_r[6:0]) + 8'd3 :
					STD_WORDS;
			wr_cnt_r    <= 7'h00;
		end else if (fall_ev) begin
			rx_sh_r   <= rx_nxt;
			bit_cnt_r <= word_done ? 6'h00 : bit_cnt_r + 6'h01;
			if (word_done)
				word_r <= word_r + 8'h01;
			if (first_w) begin
				cmd_r      <= rx_word;
				cmd_seen_r <= 1'b1;
				if (rx_word[15:13] == OP_REGISTER_WRITE_CMD &&
					8'(rx_word[6:0]) + 8'd3 > frame_len_r)
					frame_len_r <= 8'(rx_word[6:0]) + 8'd3;
			end
			if (wr_slot)
				wr_cnt_r <= wr_cnt_r + 7'h01;
		end
	end

	// response, lock and multi-read state change only at frame end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			resp_r    <= CMD_NULL;
			rmulti_r  <= 1'b0;
			lock_r    <= 1'b0;
			rm_addr_r <= 6'h00;
			rm_n_r    <= 7'h00;
		end else if (latch) begin
			resp_r    <= resp_nxt;
			rmulti_r  <= accept & is_register_read_cmd & cmd_r[6:0] != 7'h00;
			rm_addr_r <= cmd_r[12:7];
			rm_n_r    <= cmd_r[6:0];
			if (accept && cmd_r == CMD_LOCK)
				lock_r <= 1'b1;
			else if (accept && (cmd_r == CMD_UNLOCK || cmd_r == CMD_RESET))
				lock_r <= 1'b0;
		end else if (timeout_hit) begin
			rmulti_r  <= 1'b0;
		end
	end

	// channel fifos, two deep each
	logic [DW-1:0]     f0_r [NCH];
	logic [DW-1:0]     f1_r [NCH];
	logic [1:0]        fc_r [NCH];
	logic [NCH-1:0]    pop_ev, sample_ready_w;
	wire  [RAW_W-1:0]  raw_a [NCH];
	assign raw_a[0] = ch0_raw;
	assign raw_a[1] = ch1_raw;
	assign raw_a[2] = ch2_raw;

	for (genvar c = 0; c < NCH; c++) begin : g_fifo
		wire [DW-1:0] din_c = sat24(raw_a[c]);
		wire [1:0]    pc    = fc_r[c] - {1'b0, pop_ev[c]};
		assign pop_ev[c] = word_done & ~rmulti_r & fc_r[c] != 2'd0 &
			word_r == 8'(c + 1);
		assign sample_ready_w[c] = fc_r[c] != 2'd0;
		always_ff @(posedge mclk) begin
			if (sys_rst || sync_ev) begin
				fc_r[c] <= 2'd0;
			end else if (ch_done[c]) begin
				if (pc == 2'd0) begin
					f0_r[c] <= din_c;
				end else if (pc == 2'd1) begin
					if (pop_ev[c])
						f0_r[c] <= f1_r[c];
					f1_r[c] <= din_c;
				end else begin
					f0_r[c] <= f1_r[c]; // full: oldest sample dropped
					f1_r[c] <= din_c;
				end
				fc_r[c] <= (pc == 2'd2) ? 2'd2 : pc + 2'd1;
			end else if (pop_ev[c]) begin
				f0_r[c] <= f1_r[c];
				fc_r[c] <= pc;
			end
		end
	end
	assign status_w = {13'h0000, sample_ready_w};

	// output word selection and formatting, msb-aligned except for the sign-extended WL_32S
	wire  [1:0]        chi      = 2'(word_r - 8'd1);
	wire  [DW-1:0]     head     = f0_r[chi];
	wire  [31:0]       ch_fmt   = (wl_sel == WL_32S) ?
		{{8{head[DW-1]}}, head} : {head, 8'h00};
	wire               is_crc_w = rmulti_r ?
		(word_r == 8'(rm_n_r) + 8'd2) : (word_r == 8'd4);
	wire  [31:0]       tx_word  =
		(word_r == 8'd0) ? {resp_r, 16'h0000} :
		is_crc_w ? {crc_r, 16'h0000} :
		(rmulti_r && word_r <= 8'(rm_n_r) + 8'd1) ?
		{reg_val(6'(rm_addr_r + 6'(word_r) - 6'd1)), 16'h0000} :
		(!rmulti_r && word_r <= 8'd3) ? ch_fmt : 32'h00000000;
	wire               load     = rise_ev & (tx_cnt_r == 6'h00);
	wire               tx_bit   = load ? tx_word[31] : tx_sh_r[31];
	wire               crc_on   = load ? ~is_crc_w : ~tx_crc_r;
	wire  [15:0]       crc_step = {crc_r[14:0], 1'b0} ^
		((crc_r[15] ^ tx_bit) ? CRC_POLY : 16'h0000);

	always_ff @(posedge mclk) begin
		if (sys_rst || frame_rst) begin
			tx_cnt_r <= 6'h00;
			tx_sh_r  <= 32'h00000000;
			tx_crc_r <= 1'b0;
			crc_r    <= CRC_INIT;
			dout_r   <= 1'b0;
		end else if (rise_ev) begin
			dout_r   <= tx_bit;
			tx_sh_r  <= load ? {tx_word[30:0], 1'b0} : {tx_sh_r[30:0], 1'b0};
			tx_cnt_r <= load ? wbits - 6'h01 : tx_cnt_r - 6'h01;
			tx_crc_r <= load ? is_crc_w : tx_crc_r;
			if (crc_on)
				crc_r <= crc_step;
		end
	end
	assign dout = dout_r;

	always_ff @(posedge mclk) begin
		if (sys_rst)
			dout_oe <= 1'b0;
		else
			dout_oe <= selected;
	end

	// register file: host port first, serial writes override
	wire  [5:0]        wr_idx   = 6'(wr_addr_r + 6'(word_r) - 6'd1);
	always_ff @(posedge mclk) begin
		if (sys_rst)
			wr_addr_r <= 6'h00;
		else if (first_w)
			wr_addr_r <= rx_word[12:7];
	end

	for (genvar r = 2; r < REG_N; r++) begin : g_regs
		always_ff @(posedge mclk) begin
			if (sys_rst)
				regs_r[r] <= (r == int'(REG_MODE)) ? MODE_RST : 16'h0000;
			else if (latch && accept && cmd_r == CMD_RESET)
				regs_r[r] <= (r == int'(REG_MODE)) ? MODE_RST : 16'h0000;
			else if (wr_slot && wr_idx == 6'(r))
				regs_r[r] <= rx_word;
			else if (reg_wr && reg_addr == 4'(r))
				regs_r[r] <= reg_wdata;
		end
	end
	assign regs_r[0] = 16'h0000;
	assign regs_r[1] = 16'h0000;

	always_ff @(posedge mclk) begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_rd ? reg_val({2'b00, reg_addr}) : 16'h0000;
	end

	// ready events per source selection
	logic [NCH-1:0]    pend_r;
	logic [3:0]        rdy_cnt_r;
	logic              rdy_n_r, rearm_r;
	wire  [NCH-1:0]    pend_nxt = pend_r | ch_done;
	wire               all_in   = &pend_nxt;
	wire               rdy_ev   = (rdy_src == 2'b01 && !gchop) ? |ch_done :
		(rdy_src == 2'b00 || gchop) ? (all_in & |ch_done) :
		(|ch_done & pend_r == 3'b000);
	wire               read_done = pop_ev[NCH-1];

	always_ff @(posedge mclk) begin
		if (sys_rst || sync_ev)
			pend_r <= 3'b000;
		else
			pend_r <= all_in ? 3'b000 : pend_nxt;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || sync_ev) begin
			rdy_n_r   <= 1'b1;
			rdy_cnt_r <= 4'h0;
			rearm_r   <= 1'b0;
		end else if (rdy_ev) begin
			rdy_n_r   <= 1'b0;
			rdy_cnt_r <= rdy_fmt ? RDY_PULSE_CYC : 4'h0;
			rearm_r   <= 1'b0;
		end else if (rdy_cnt_r != 4'h0) begin
			rdy_cnt_r <= rdy_cnt_r - 4'h1;
			rdy_n_r   <= rdy_cnt_r == 4'h1;
		end else if (!rdy_fmt && read_done) begin
			rdy_n_r   <= 1'b1;
			rearm_r   <= 1'b1;
		end else begin
			if (rearm_r && sample_ready_w != 3'b000)
				rdy_n_r <= 1'b0;
			rearm_r <= 1'b0;
		end
	end
	assign sample_ready_n = rdy_n_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_first_word;
		first_w && !frame_full && !timeout_hit && !cs_rise;
	endsequence
	sequence s_cmd_held;
		cmd_seen_r && cmd_r == $past(rx_word);
	endsequence

	property p_wl_reset;
		disable iff (1'b0) sys_rst |=> wl_sel == WL_24;
	endproperty
	a_wl_reset: assert property (p_wl_reset)
		else $error("word length not 24 bits after reset");

	property p_cmd_take;
		s_first_word |=> s_cmd_held;
	endproperty
	a_cmd_take: assert property (p_cmd_take)
		else $error("command word not captured from first word");

	property p_timeout;
		timeout_hit |=> word_r == 8'h00 && state_r == LS_IDLE &&
			tx_cnt_r == 6'h00;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("link not reset after frame timeout");

	property p_float;
		!selected |=> !dout_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("dout driven while deselected");

	property p_null_resp;
		latch && cmd_r == CMD_NULL |=> resp_r == $past(status_w);
	endproperty
	a_null_resp: assert property (p_null_resp)
		else $error("no-operation response is not status");

	property p_flush;
		sync_ev |=> status_w == 16'h0000;
	endproperty
	a_flush: assert property (p_flush)
		else $error("fifos not emptied by sync strobe");

	property p_sat;
		ch_done[0] && fc_r[0] == 2'd0 && !sync_ev &&
			$signed(ch0_raw) > $signed(26'h07fffff) |=> f0_r[0] == 24'h7fffff;
	endproperty
	a_sat: assert property (p_sat)
		else $error("positive sample not clipped to 7fffff");

	property p_keep_two;
		ch_done[0] && fc_r[0] == 2'd2 && !pop_ev[0] && !sync_ev
			|=> fc_r[0] == 2'd2 && sample_ready_w[0];
	endproperty
	a_keep_two: assert property (p_keep_two)
		else $error("two-deep fifo lost its count");

	property p_read_clear;
		pop_ev[0] && fc_r[0] == 2'd1 && !ch_done[0] && !sync_ev
			|=> !sample_ready_w[0];
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("ready bit not cleared after read");

	property p_len16;
		load && wl_sel == WL_16 && !frame_rst |=> tx_cnt_r == 6'd15;
	endproperty
	a_len16: assert property (p_len16)
		else $error("16-bit word length not applied");

	property p_sign32;
		load && !rmulti_r && word_r == 8'd1 && wl_sel == WL_32S &&
			!frame_rst |=> dout == $past(f0_r[0][DW-1]);
	endproperty
	a_sign32: assert property (p_sign32)
		else $error("32-bit sign extension wrong");
endmodule : adc_spi_frame_out

// ---- test/spi_host_model.sv ----
module spi_host_model (
	input  wire logic mclk,
	input  wire logic dout,
	input  wire logic dout_oe,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] tx [0:7];
	logic [31:0] rx [0:7];
	logic        oe_mid;
	logic        oe_after;
	logic        hold_r;
	int          stall_cyc;
	wire         miso;
	// a released line shows the inverse of its last driven bit
	assign miso = dout_oe ? dout : ~hold_r;
	always @(posedge mclk) if (dout_oe) hold_r <= dout;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
		hold_r = 1'b0;
		stall_cyc = 0;
	end
	task automatic xfer(input int wl, input int nw);
		logic [31:0] sh;
		@(posedge mclk) cs_n <= 1'b0;
		repeat (8) @(posedge mclk);
		if (stall_cyc > 0) begin
			// one stray bit, then a pause beyond the frame timeout
			sclk <= 1'b1;
			repeat (4) @(posedge mclk);
			sclk <= 1'b0;
			repeat (stall_cyc) @(posedge mclk);
			stall_cyc = 0;
		end
		for (int i = 0; i < nw; i++) begin
			sh = {16'h0, tx[i]} << (wl - 16);
			rx[i] = 32'h0;
			for (int b = wl - 1; b >= 0; b--) begin
				sclk <= 1'b1;
				din <= sh[b];
				repeat (4) @(posedge mclk);
				sclk <= 1'b0;
				repeat (4) @(posedge mclk);
				rx[i] = {rx[i][30:0], miso};
			end
		end
		oe_mid = dout_oe;
		repeat (4) @(posedge mclk);
		// frames end well inside the timeout
		cs_n <= 1'b1;
		din <= ~din;
		repeat (16) @(posedge mclk);
		oe_after = dout_oe;
	endtask : xfer
endmodule : spi_host_model

// ---- test/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_spi_pkg::*;
	logic        mclk;
	logic        sys_rst;
	logic        cs_n_pin;
	logic        sclk_pin;
	logic        din_pin;
	logic        sync_n;
	logic        dout;
	logic        dout_oe;
	logic        rdy_n;
	logic [2:0]  ch_done;
	logic [25:0] r0, r1, r2;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [25:0] va [0:3];
	logic [1:0]  wls [0:2];
	int          fail_count;
	int          n_compared;

	adc_spi_frame_out #(.FRAME_TIMEOUT_CYC(TIMEOUT_CYC)) u_adc_spi_frame_out (
		.mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin), .din_pin(din_pin), .sync_reset_n_pin(sync_n),
		.dout(dout), .dout_oe(dout_oe), .sample_ready_n(rdy_n),
		.ch_done(ch_done), .ch0_raw(r0), .ch1_raw(r1), .ch2_raw(r2),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	spi_host_model u_host (.mclk(mclk), .dout(dout), .dout_oe(dout_oe),
		.cs_n(cs_n_pin), .sclk(sclk_pin), .din(din_pin));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	function automatic logic [23:0] clip(input logic [25:0] r);
		if ($signed(r) > $signed(26'h07fffff)) return 24'h7fffff;
		if ($signed(r) < $signed(26'h3800000)) return 24'h800000;
		return r[23:0];
	endfunction : clip
	function automatic logic [31:0] fmt(input logic [23:0] s,
		input logic [1:0] wl);
		case (wl)
			WL_16:   return {16'h0, s[23:8]};
			WL_24:   return {8'h0, s};
			WL_32Z:  return {s, 8'h0};
			default: return {{8{s[23]}}, s};
		endcase
	endfunction : fmt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a[3:0];
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_addr <= a[3:0];
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		chk({16'h0, reg_rdata}, {16'h0, e});
	endtask : rdchk
	task automatic push(input int a, input int b, input int c);
		@(posedge mclk);
		r0 <= va[a];
		r1 <= va[b];
		r2 <= va[c];
		ch_done <= 3'h7;
		@(posedge mclk);
		ch_done <= 3'h0;
		repeat (4) @(posedge mclk);
	endtask : push
	task automatic frame(input logic [15:0] c, input logic [15:0] d1,
		input logic [15:0] d2, input int nw, input logic [1:0] wl);
		for (int i = 0; i < 8; i++) u_host.tx[i] = 16'h0;
		u_host.tx[0] = c;
		u_host.tx[1] = d1;
		u_host.tx[2] = d2;
		u_host.xfer((wl == WL_16) ? 16 : (wl == WL_24) ? 24 : 32, nw);
	endtask : frame
	task automatic chkdata(input int a, input int b, input int c,
		input logic [1:0] wl);
		chk(u_host.rx[1], fmt(clip(va[a]), wl));
		chk(u_host.rx[2], fmt(clip(va[b]), wl));
		chk(u_host.rx[3], fmt(clip(va[c]), wl));
	endtask : chkdata

	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		test_done();
	end

	initial begin
		sys_rst = 1'b1;
		sync_n = 1'b1;
		ch_done = 3'h0;
		{r0, r1, r2} = '0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		fail_count = 0;
		n_compared = 0;
		va = '{26'h0123456, 26'h3fedcba, 26'h1ffffff, 26'h2000000};
		wls = '{WL_16, WL_32Z, WL_32S};
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		rdchk(REG_MODE, MODE_RST);
		rdchk(6'h0f, 16'h0000);
		wr(REG_STATUS, 16'hffff);
		rdchk(REG_STATUS, 16'h0000);
		chk({31'h0, dout_oe}, 32'h0);
		// two sets queued, then drained one frame at a time
		push(0, 1, 2);
		chk({31'h0, rdy_n}, 32'h0);
		push(3, 0, 1);
		rdchk(REG_STATUS, 16'h0007);
		frame(CMD_NULL, 16'h0, 16'h0, 5, WL_24);
		chkdata(0, 1, 2, WL_24);
		chk({24'h0, u_host.rx[4][7:0]}, 32'h0);
		chk({30'h0, u_host.oe_mid, u_host.oe_after}, 32'h2);
		chk({31'h0, rdy_n}, 32'h0);
		rdchk(REG_STATUS, 16'h0007);
		frame(16'h0f0f, 16'h0, 16'h0, 5, WL_24);
		chk(u_host.rx[0], 32'h000700);
		chkdata(3, 0, 1, WL_24);
		rdchk(REG_STATUS, 16'h0000);
		chk({31'h0, rdy_n}, 32'h1);
		for (int k = 0; k < 3; k++) begin
			wr(REG_MODE, {6'h0, wls[k], 8'h10});
			push(2, 3, 1);
			frame(CMD_NULL, 16'h0, 16'h0, 5, wls[k]);
			chk(u_host.rx[0], 32'h0);
			chkdata(2, 3, 1, wls[k]);
		end
		wr(REG_MODE, MODE_RST);
		frame(16'h6181, 16'h1234, 16'h5678, 4, WL_24);
		rdchk(6'h03, 16'h1234);
		rdchk(6'h04, 16'h5678);
		frame(16'ha181, 16'h0, 16'h0, 5, WL_24);
		chk(u_host.rx[0], 32'h418100);
		frame(CMD_NULL, 16'h0, 16'h0, 4, WL_24);
		chk(u_host.rx[0], 32'he18100);
		chk(u_host.rx[1], 32'h123400);
		chk(u_host.rx[2], 32'h567800);
		// a stalled frame is dropped by the timeout, the next one realigns
		push(0, 1, 2);
		u_host.stall_cyc = 33000;
		frame(CMD_NULL, 16'h0, 16'h0, 5, WL_24);
		chkdata(0, 1, 2, WL_24);
		// a sync strobe empties a full fifo; a third set drops the oldest
		push(0, 1, 2);
		push(3, 0, 1);
		push(2, 3, 0);
		rdchk(REG_STATUS, 16'h0007);
		sync_n <= 1'b0;
		repeat (8) @(posedge mclk);
		sync_n <= 1'b1;
		repeat (8) @(posedge mclk);
		rdchk(REG_STATUS, 16'h0000);
		test_done();
	end
endmodule : tb_top
